// [cpsb_consts.svh]
// timing and field constants for the cpu power control sideband
`ifndef CPSB_CONSTS_SVH
`define CPSB_CONSTS_SVH
`define CPSB_BRANCH_W     4
`define CPSB_SENSE_W      8
`define CPSB_EXT_TGT_N    14
`define CPSB_SYNC_STAGES  2
`define CPSB_WAKE_HOLD    4'h4
`define CPSB_PWR_DELAY    4'h8
`define CPSB_RST_DELAY    4'h6
`endif

// [cpsb_dev.sv]
// subsystem end of the cpu control, status and power sideband
`timescale 1ns/1ns
`default_nettype none
`include "cpsb_consts.svh"
module cpsb_dev #(
	parameter int SYNC_STAGES = `CPSB_SYNC_STAGES
) (
	// clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_b,
	// core state
	input  wire logic                  i_core_in_debug,
	input  wire logic                  i_core_sleep,
	input  wire logic                  i_core_sleep_deep,
	input  wire logic                  i_core_lockup,
	input  wire logic                  i_wake_event,
	input  wire cpsb_pkg::cpsb_sense_type  i_wake_lines,
	input  wire logic                  i_trace_on,
	input  wire logic                  i_trace_unit_on,
	input  wire logic                  i_trigger_match,
	input  wire cpsb_pkg::cpsb_branch_type i_branch_decode,
	input  wire logic                  i_reset_request_control_bit,
	input  wire logic                  i_protection_unit_disable,
	input  wire logic                  i_protection_unit_present,
	// debugger requests
	input  wire logic                  i_dbg_pwr_want,
	input  wire logic                  i_sys_pwr_want,
	input  wire logic                  i_dbg_rst_want,
	// interconnect selects
	input  wire logic                  i_timer_a_sel,
	input  wire logic                  i_timer_b_sel,
	input  wire logic                  i_other_apb_sel,
	input  wire cpsb_pkg::cpsb_tgt_type    i_ext_sel,
	// sideband
	cpsb_if.dev                        sb,
	// user side status
	output logic                       o_core_hold_asleep,
	output logic                       o_protection_unit_visible,
	output logic                       o_trace_enabled_status,
	output logic                       o_trace_unit_enabled_status,
	output logic                       o_trace_trigger_out,
	output cpsb_pkg::cpsb_branch_type  o_branch_decode_status,
	output logic                       o_dbg_pwr_ok,
	output logic                       o_sys_pwr_ok,
	output logic                       o_dbg_rst_done,
	output logic                       o_debug_bus_clamp,
	output cpsb_pkg::cpsb_tgt_type     o_ext_apb_target_select
);
	import cpsb_pkg::*;

	logic halted, sleeping, deep, lockup, hold_ack_n, wake, wic_ack, sysrst;
	logic dpu_req, spu_req, drst_req, apb_act, ta_act, tb_act, hold_asleep;
	logic pu_vis, trc, trcu, trig, clamp;
	cpsb_branch_type brch;
	cpsb_sense_type  sense;
	cpsb_tgt_type    ext_sel;
	logic [2:0] ack_raw, ack_sync;
	logic [SYNC_STAGES-1:0] sync_q [3];

	// resynchronise the three asynchronous acknowledges
	assign ack_raw = {sb.debug_reset_ack, sb.system_power_up_ack, sb.debug_power_up_ack};
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_sync
			always_ff @(posedge i_clk) begin
				if (!i_rst_b)
					sync_q[g] <= '0;
				else
					sync_q[g] <= {sync_q[g][SYNC_STAGES-2:0], ack_raw[g]};
			end
			assign ack_sync[g] = sync_q[g][SYNC_STAGES-1];
		end
	endgenerate

	// four-phase request: rise on want, fall only once ack is seen high
	function automatic logic next_req(input logic req, input logic want, input logic ack);
		next_req = req ? !(ack && !want) : (want && !ack);
	endfunction

	wire next_dpu_req  = next_req(dpu_req, i_dbg_pwr_want, ack_sync[0]);
	wire next_spu_req  = next_req(spu_req, i_sys_pwr_want, ack_sync[1]);
	wire next_drst_req = next_req(drst_req, i_dbg_rst_want, ack_sync[2]);

	// sleep extension: acked only while sleeping, ack falls after req
	wire hold_active   = !sb.sleep_extend_req_n && (i_core_sleep || hold_asleep);
	wire next_hold     = hold_active;
	// wake controller ack tracks req so it falls only after req falls
	wire next_wic_ack  = sb.wake_ctrl_enable_req;
	wire sleeping_now  = i_core_sleep || hold_asleep;

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			halted      <= 1'b0;
			sleeping    <= 1'b0;
			deep        <= 1'b0;
			lockup      <= 1'b0;
			hold_ack_n  <= 1'b1;
			hold_asleep <= 1'b0;
			wake        <= 1'b0;
			sense       <= '0;
			wic_ack     <= 1'b0;
			sysrst      <= 1'b0;
			dpu_req     <= 1'b0;
			spu_req     <= 1'b0;
			drst_req    <= 1'b0;
			apb_act     <= 1'b0;
			ta_act      <= 1'b0;
			tb_act      <= 1'b0;
			ext_sel     <= '0;
			pu_vis      <= 1'b0;
			trc         <= 1'b0;
			trcu        <= 1'b0;
			trig        <= 1'b0;
			brch        <= '0;
			clamp       <= 1'b1;
		end else begin
			halted      <= i_core_in_debug;
			sleeping    <= sleeping_now;
			deep        <= sleeping_now && i_core_sleep_deep;
			lockup      <= i_core_lockup;
			hold_asleep <= next_hold;
			hold_ack_n  <= !next_hold;
			wake        <= i_wake_event;
			sense       <= i_wake_event ? i_wake_lines : '0;
			wic_ack     <= next_wic_ack;
			sysrst      <= i_reset_request_control_bit;
			dpu_req     <= next_dpu_req;
			spu_req     <= next_spu_req;
			drst_req    <= next_drst_req;
			apb_act     <= i_timer_a_sel || i_timer_b_sel || i_other_apb_sel || (|i_ext_sel);
			ta_act      <= i_timer_a_sel;
			tb_act      <= i_timer_b_sel;
			ext_sel     <= i_ext_sel;
			pu_vis      <= !i_protection_unit_disable && i_protection_unit_present;
			trc         <= i_trace_on;
			trcu        <= i_trace_unit_on;
			trig        <= i_trigger_match;
			brch        <= i_branch_decode;
			clamp       <= !sb.debug_power_down_clamp_n;
		end
	end

	assign sb.core_halted_status     = halted;
	assign sb.core_sleeping_status   = sleeping;
	assign sb.core_deep_sleep_status = deep;
	assign sb.sleep_extend_ack_n     = hold_ack_n;
	assign sb.wake_event_out         = wake;
	assign sb.wake_source_sense      = sense;
	assign sb.wake_ctrl_enable_ack   = wic_ack;
	assign sb.system_reset_request   = sysrst;
	assign sb.core_lockup_status     = lockup;
	assign sb.debug_power_up_req     = dpu_req;
	assign sb.system_power_up_req    = spu_req;
	assign sb.debug_reset_req        = drst_req;
	assign sb.apb_bus_active         = apb_act;
	assign sb.timer_a_bus_active     = ta_act;
	assign sb.timer_b_bus_active     = tb_act;

	assign o_core_hold_asleep          = hold_asleep;
	assign o_protection_unit_visible   = pu_vis;
	assign o_trace_enabled_status      = trc;
	assign o_trace_unit_enabled_status = trcu;
	assign o_trace_trigger_out         = trig;
	assign o_branch_decode_status      = brch;
	assign o_dbg_pwr_ok                = ack_sync[0];
	assign o_sys_pwr_ok                = ack_sync[1];
	assign o_dbg_rst_done              = ack_sync[2];
	assign o_debug_bus_clamp           = clamp;
	assign o_ext_apb_target_select     = ext_sel;
endmodule
`default_nettype wire

// [cpsb_if.sv]
// sideband wires between the subsystem and its power controller
`timescale 1ns/1ns
`default_nettype none
interface cpsb_if;
	import cpsb_pkg::*;
	logic            core_halted_status;
	logic            core_sleeping_status;
	logic            core_deep_sleep_status;
	logic            sleep_extend_req_n;
	logic            sleep_extend_ack_n;
	logic            wake_event_out;
	cpsb_sense_type  wake_source_sense;
	logic            wake_ctrl_enable_req;
	logic            wake_ctrl_enable_ack;
	logic            system_reset_request;
	logic            core_lockup_status;
	logic            debug_power_up_req;
	logic            debug_power_up_ack;
	logic            system_power_up_req;
	logic            system_power_up_ack;
	logic            debug_reset_req;
	logic            debug_reset_ack;
	logic            debug_power_down_clamp_n;
	logic            apb_bus_active;
	logic            timer_a_bus_active;
	logic            timer_b_bus_active;
	modport dev (
		output core_halted_status, core_sleeping_status, core_deep_sleep_status,
		input  sleep_extend_req_n,
		output sleep_extend_ack_n, wake_event_out, wake_source_sense,
		input  wake_ctrl_enable_req,
		output wake_ctrl_enable_ack, system_reset_request, core_lockup_status,
		output debug_power_up_req, system_power_up_req, debug_reset_req,
		input  debug_power_up_ack, system_power_up_ack, debug_reset_ack,
		input  debug_power_down_clamp_n,
		output apb_bus_active, timer_a_bus_active, timer_b_bus_active
	);
	modport pmu (
		input  core_halted_status, core_sleeping_status, core_deep_sleep_status,
		output sleep_extend_req_n,
		input  sleep_extend_ack_n, wake_event_out, wake_source_sense,
		output wake_ctrl_enable_req,
		input  wake_ctrl_enable_ack, system_reset_request, core_lockup_status,
		input  debug_power_up_req, system_power_up_req, debug_reset_req,
		output debug_power_up_ack, system_power_up_ack, debug_reset_ack,
		output debug_power_down_clamp_n,
		input  apb_bus_active, timer_a_bus_active, timer_b_bus_active
	);
endinterface
`default_nettype wire

// [cpsb_monitor.sv]
// assertions on the sideband wires between the two ends
`timescale 1ns/1ns
`default_nettype none
module cpsb_monitor (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// sleep and wake
	input wire logic core_sleeping_status,
	input wire logic core_deep_sleep_status,
	input wire logic sleep_extend_req_n,
	input wire logic sleep_extend_ack_n,
	input wire logic wake_ctrl_enable_req,
	input wire logic wake_ctrl_enable_ack,
	// debug and system power, and debug reset
	input wire logic debug_power_up_req,
	input wire logic debug_power_up_ack,
	input wire logic system_power_up_req,
	input wire logic system_power_up_ack,
	input wire logic debug_reset_req,
	input wire logic debug_reset_ack
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	chk_sleep_req_only: assert property (!sleep_extend_req_n |-> core_sleeping_status)
		else $error("sleep extend request while not sleeping");
	chk_deep_in_sleep: assert property (core_deep_sleep_status |-> core_sleeping_status)
		else $error("deep sleep status without sleeping status");
	chk_sleep_ack_follow: assert property ((!sleep_extend_req_n && core_sleeping_status) |=> !sleep_extend_ack_n)
		else $error("sleep extend not acknowledged");
	chk_sleep_ack_release: assert property (sleep_extend_req_n |=> sleep_extend_ack_n)
		else $error("sleep extend ack held after release");
	chk_wake_ack_match: assert property (wake_ctrl_enable_ack == $past(wake_ctrl_enable_req))
		else $error("wake controller ack does not follow request");
	chk_dbg_req_hold: assert property (debug_power_up_req && !debug_power_up_ack |=> debug_power_up_req)
		else $error("debug power request dropped before ack");
	chk_dbg_ack_hold: assert property (debug_power_up_ack && debug_power_up_req |=> debug_power_up_ack)
		else $error("debug power ack dropped before request");
	chk_dbg_ack_time: assert property ($rose(debug_power_up_req) |-> ##[9:14] debug_power_up_ack)
		else $error("debug power ack late");
	chk_sys_ack_time: assert property ($rose(system_power_up_req) |-> ##[9:14] system_power_up_ack)
		else $error("system power ack late");
	chk_rst_ack_time: assert property ($rose(debug_reset_req) |-> ##[7:12] debug_reset_ack)
		else $error("debug reset ack late");
	chk_rst_req_hold: assert property (debug_reset_req && !debug_reset_ack |=> debug_reset_req)
		else $error("debug reset request dropped before ack");
	cover property (!sleep_extend_ack_n);
	cover property ($rose(debug_power_up_ack));
	cover property ($rose(wake_ctrl_enable_ack));
endmodule
`default_nettype wire

// [cpsb_pkg.sv]
// types shared by both ends of the cpu power control sideband
`include "cpsb_consts.svh"
package cpsb_pkg;
	typedef logic [`CPSB_BRANCH_W-1:0]  cpsb_branch_type;
	typedef logic [`CPSB_SENSE_W-1:0]   cpsb_sense_type;
	typedef logic [`CPSB_EXT_TGT_N-1:0] cpsb_tgt_type;
	typedef enum logic [1:0] {
		CPSB_RUN   = 2'h0,
		CPSB_SLEEP = 2'h1,
		CPSB_DEEP  = 2'h2,
		CPSB_HOLD  = 2'h3
	} cpsb_pwr_type;
endpackage

// [cpsb_pmu.sv]
// power controller end of the cpu control, status and power sideband
`timescale 1ns/1ns
`default_nettype none
`include "cpsb_consts.svh"
module cpsb_pmu (
	// clock and reset
	input  wire logic   i_clk,
	input  wire logic   i_rst_b,
	// user side controls
	input  wire logic   i_want_sleep_extend,
	input  wire logic   i_want_wic_sleep,
	input  wire logic   i_debug_power_off,
	// sideband
	cpsb_if.pmu         sb,
	// user side status
	output logic        o_core_awake_needed,
	output logic        o_reset_request_seen,
	output logic        o_dbg_domain_on,
	output logic        o_apb_clock_enable
);
	import cpsb_pkg::*;

	logic [1:0] s_dpu, s_spu, s_drst;
	logic [3:0] cnt_dpu, cnt_spu, cnt_drst;
	logic ack_dpu, ack_spu, ack_drst, hold_n, wic_req, pdn_n, wake_q, rst_q, apb_q;

	// requests come from the debug domain and are synchronised first
	wire dpu_s  = s_dpu[1];
	wire spu_s  = s_spu[1];
	wire drst_s = s_drst[1];

	wire next_hold_n  = !(i_want_sleep_extend && sb.core_sleeping_status);
	wire next_wic_req = wic_req ? !(!i_want_wic_sleep && sb.wake_ctrl_enable_ack)
		: (i_want_wic_sleep && !sb.wake_ctrl_enable_ack);

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			s_dpu <= '0;
			s_spu <= '0;
			s_drst <= '0;
			cnt_dpu <= '0;
			cnt_spu <= '0;
			cnt_drst <= '0;
			ack_dpu <= 1'b0;
			ack_spu <= 1'b0;
			ack_drst <= 1'b0;
			hold_n <= 1'b1;
			wic_req <= 1'b0;
			pdn_n <= 1'b0;
			wake_q <= 1'b0;
			rst_q <= 1'b0;
			apb_q <= 1'b0;
		end else begin
			s_dpu <= {s_dpu[0], sb.debug_power_up_req};
			s_spu <= {s_spu[0], sb.system_power_up_req};
			s_drst <= {s_drst[0], sb.debug_reset_req};
			// ack after a settle delay; drop once request has fallen
			cnt_dpu <= dpu_s ? ((cnt_dpu == `CPSB_PWR_DELAY) ? cnt_dpu : cnt_dpu + 4'h1) : 4'h0;
			cnt_spu <= spu_s ? ((cnt_spu == `CPSB_PWR_DELAY) ? cnt_spu : cnt_spu + 4'h1) : 4'h0;
			cnt_drst <= drst_s ? ((cnt_drst == `CPSB_RST_DELAY) ? cnt_drst : cnt_drst + 4'h1) : 4'h0;
			ack_dpu <= dpu_s && (cnt_dpu == `CPSB_PWR_DELAY);
			ack_spu <= spu_s && (cnt_spu == `CPSB_PWR_DELAY);
			ack_drst <= drst_s && (cnt_drst == `CPSB_RST_DELAY);
			hold_n <= next_hold_n;
			wic_req <= next_wic_req;
			pdn_n <= !i_debug_power_off;
			wake_q <= sb.wake_event_out;
			rst_q <= sb.system_reset_request;
			apb_q <= sb.apb_bus_active;
		end
	end

	assign sb.debug_power_up_ack       = ack_dpu;
	assign sb.system_power_up_ack      = ack_spu;
	assign sb.debug_reset_ack          = ack_drst;
	assign sb.sleep_extend_req_n       = hold_n;
	assign sb.wake_ctrl_enable_req     = wic_req;
	assign sb.debug_power_down_clamp_n = pdn_n;
	assign o_core_awake_needed         = wake_q;
	assign o_reset_request_seen        = rst_q;
	assign o_dbg_domain_on             = ack_dpu;
	assign o_apb_clock_enable          = apb_q;
endmodule
`default_nettype wire

// [tb_top.sv]
// self-checking bench joining both sideband ends
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import cpsb_pkg::*;
	logic i_clk = 1'b0, i_rst_b = 1'b0;
	logic dbg = 0, slp = 0, dp = 0, lk = 0, wk = 0, tr = 0, tu = 0, tg = 0, rc = 0, pd = 0, pp = 1;
	logic dw = 0, sw = 0, rw = 0, ta = 0, tbs = 0, oa = 0, wx = 0, wic = 0, poff = 0;
	cpsb_sense_type wl = 8'h00;
	cpsb_branch_type br = 4'h0, bro;
	cpsb_tgt_type es = 14'h0000, eso;
	logic hold, vis, tre, tue, trg, dok, sok, rdn, clp, awk, rsn, don, ace;
	int n_fail = 0, n_compared = 0, cyc = 0, k;
	cpsb_if sb_if ();
	always #20 i_clk = ~i_clk;
	cpsb_dev cpsb_dev_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_core_in_debug(dbg),
		.i_core_sleep(slp), .i_core_sleep_deep(dp), .i_core_lockup(lk), .i_wake_event(wk),
		.i_wake_lines(wl), .i_trace_on(tr), .i_trace_unit_on(tu), .i_trigger_match(tg),
		.i_branch_decode(br), .i_reset_request_control_bit(rc), .i_protection_unit_disable(pd),
		.i_protection_unit_present(pp), .i_dbg_pwr_want(dw), .i_sys_pwr_want(sw),
		.i_dbg_rst_want(rw), .i_timer_a_sel(ta), .i_timer_b_sel(tbs), .i_other_apb_sel(oa),
		.i_ext_sel(es), .sb(sb_if.dev), .o_core_hold_asleep(hold), .o_protection_unit_visible(vis),
		.o_trace_enabled_status(tre), .o_trace_unit_enabled_status(tue), .o_trace_trigger_out(trg),
		.o_branch_decode_status(bro), .o_dbg_pwr_ok(dok), .o_sys_pwr_ok(sok),
		.o_dbg_rst_done(rdn), .o_debug_bus_clamp(clp), .o_ext_apb_target_select(eso));
	cpsb_pmu cpsb_pmu_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_want_sleep_extend(wx),
		.i_want_wic_sleep(wic), .i_debug_power_off(poff), .sb(sb_if.pmu),
		.o_core_awake_needed(awk), .o_reset_request_seen(rsn), .o_dbg_domain_on(don),
		.o_apb_clock_enable(ace));
	cpsb_monitor cpsb_monitor_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.core_sleeping_status(sb_if.core_sleeping_status),
		.core_deep_sleep_status(sb_if.core_deep_sleep_status),
		.sleep_extend_req_n(sb_if.sleep_extend_req_n), .sleep_extend_ack_n(sb_if.sleep_extend_ack_n),
		.wake_ctrl_enable_req(sb_if.wake_ctrl_enable_req),
		.wake_ctrl_enable_ack(sb_if.wake_ctrl_enable_ack),
		.debug_power_up_req(sb_if.debug_power_up_req), .debug_power_up_ack(sb_if.debug_power_up_ack),
		.system_power_up_req(sb_if.system_power_up_req),
		.system_power_up_ack(sb_if.system_power_up_ack),
		.debug_reset_req(sb_if.debug_reset_req), .debug_reset_ack(sb_if.debug_reset_ack));
	task automatic tick(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic final_report;
		if (n_fail == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// hang guard well above the hundred or so cycles the sequence needs
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			final_report;
		end
	end
	initial begin
		tick(10);
		i_rst_b = 1'b1;
		tick(2);
		for (int p = 0; p < 2; p++) begin
			{dbg, slp, dp, lk, rc, tr, tu, tg} = {8{p[0]}};
			br = p[0] ? 4'hA : 4'h5;
			pd = !p[0];
			tick(3);
			chk("halted", p, sb_if.core_halted_status);
			chk("visible", p, vis);
			chk("sleeping", p, sb_if.core_sleeping_status);
			chk("deep", p, sb_if.core_deep_sleep_status);
			chk("trace", {p[0], p[0]}, {tre, tue});
			chk("sysreset", {p[0], p[0]}, {sb_if.system_reset_request, rsn});
			chk("lockup", p, sb_if.core_lockup_status);
			chk("branch", p[0] ? 4'hA : 4'h5, bro);
			chk("trigger", p, trg);
		end
		{dbg, slp, dp, lk, rc, tr, tu, tg} = 8'h00;
		pp = 1'b0;
		// let sleeping status settle low before the controller wants an extension
		tick(2);
		chk("absent", 0, vis);
		wx = 1'b1;
		tick(3);
		chk("req_n_awake", 1, sb_if.sleep_extend_req_n);
		slp = 1'b1;
		tick(4);
		chk("req_n", 0, sb_if.sleep_extend_req_n);
		chk("ack_hold", 2'h1, {sb_if.sleep_extend_ack_n, hold});
		chk("deep_off", 0, sb_if.core_deep_sleep_status);
		slp = 1'b0;
		tick(3);
		chk("held_asleep", 2'h3, {sb_if.core_sleeping_status, hold});
		wx = 1'b0;
		tick(3);
		chk("ack_release", 2'h2, {sb_if.sleep_extend_ack_n, hold});
		chk("woke", 0, sb_if.core_sleeping_status);
		wic = 1'b1;
		tick(3);
		chk("wic_ack", 1, sb_if.wake_ctrl_enable_ack);
		wic = 1'b0;
		tick(3);
		chk("wic_ack_low", 0, sb_if.wake_ctrl_enable_ack);
		wk = 1'b1;
		wl = 8'h3C;
		tick(3);
		chk("wake", 2'h3, {sb_if.wake_event_out, awk});
		chk("sense", 8'h3C, sb_if.wake_source_sense);
		wk = 1'b0;
		tick(8);
		chk("wake_off", 0, sb_if.wake_event_out);
		{dw, sw, rw} = 3'h7;
		for (k = 0; k < 30 && sb_if.debug_power_up_ack !== 1'b1; k++) tick(1);
		chk("ack_sync_lag", 0, dok);
		for (k = 0; k < 30 && (dok & sok & rdn) !== 1'b1; k++) tick(1);
		chk("pwr_ok", 3'h7, {dok, sok, don});
		chk("rst_done", 1, rdn);
		chk("req_held", 3'h7, {sb_if.debug_power_up_req, sb_if.system_power_up_req,
			sb_if.debug_reset_req});
		{dw, sw, rw} = 3'h0;
		tick(12);
		chk("hs_idle", 0, {sb_if.debug_power_up_req, sb_if.debug_power_up_ack,
			sb_if.system_power_up_ack, sb_if.debug_reset_ack, dok, sok, rdn});
		poff = 1'b1;
		tick(5);
		chk("clamp_on", 2'h1, {sb_if.debug_power_down_clamp_n, clp});
		poff = 1'b0;
		tick(5);
		chk("clamp_off", 2'h2, {sb_if.debug_power_down_clamp_n, clp});
		for (int i = 0; i < 4; i++) begin
			{ta, tbs, oa} = 3'b100 >> i;
			es = (i == 1) ? 14'h2001 : 14'h0000;
			tick(3);
			chk("apb_active", {(i < 3), (i < 3)}, {sb_if.apb_bus_active, ace});
			chk("timer_active", {(i == 0), (i == 1)}, {sb_if.timer_a_bus_active,
				sb_if.timer_b_bus_active});
			chk("ext_select", es, eso);
		end
		final_report;
	end
endmodule
`default_nettype wire
